// ---- verilog/bssm_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module bssm_core #(
  parameter int unsigned SETTLE_CYCLES = bssm_pkg::SETTLE_CYCLES,
  parameter int unsigned INTERVAL_CYCLES = bssm_pkg::SAMPLE_INTERVAL_CYCLES,
  parameter int unsigned SAMPLE_WIDTH = bssm_pkg::SAMPLE_WIDTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic oscillator_rate_strap,
  input wire logic pwm_top_off,
  input wire logic inductor_zero,
  input wire logic constant_current_phase,
  input wire logic charge_below_burst_entry,
  input wire logic charge_above_burst_exit,
  input wire logic [SAMPLE_WIDTH-1:0] open_circuit_code,
  input wire logic [SAMPLE_WIDTH-1:0] power_point_sense_code,
  output logic top_switch_on,
  output logic bottom_switch_on,
  output logic charger_enable,
  output logic burst_active,
  output logic charge_reduce,
  output logic [SAMPLE_WIDTH-1:0] held_sample,
  output logic sample_valid
);
  ////////////////////////////////////////////////////////////////////////////
  generate
    if (SETTLE_CYCLES < 1 || INTERVAL_CYCLES < 1) begin : g_bad_count
      $error("bssm_core: timing counts must be at least one");
    end
    if (SAMPLE_WIDTH < 1) begin : g_bad_width
      $error("bssm_core: sample width must be at least one");
    end
  endgenerate

  localparam int DIV_W = $clog2(bssm_pkg::OSC_SLOW_DIV + 1);
  localparam int MP_W = $clog2(
    (SETTLE_CYCLES > INTERVAL_CYCLES ? SETTLE_CYCLES : INTERVAL_CYCLES) + 1);
  localparam logic [DIV_W-1:0] FAST_LAST =
    DIV_W'(bssm_pkg::OSC_FAST_DIV - 1);
  localparam logic [DIV_W-1:0] SLOW_LAST =
    DIV_W'(bssm_pkg::OSC_SLOW_DIV - 1);
  localparam logic [3:0] DROP_LIMIT = 4'(bssm_pkg::DROPOUT_LIMIT);
  localparam logic [5:0] REFR_LIMIT = 6'(bssm_pkg::REFRESH_LIMIT);
  localparam logic [2:0] REFR_PULSE = 3'(bssm_pkg::REFRESH_PULSE);
  localparam logic [1:0] BURST_LAST = 2'(bssm_pkg::BURST_DIV - 1);
  localparam logic [MP_W-1:0] SETTLE_LAST = MP_W'(SETTLE_CYCLES - 1);
  localparam logic [MP_W-1:0] INTERVAL_LAST = MP_W'(INTERVAL_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Strap and analog comparator levels arrive from outside the clock domain
  logic [5:0] pins_sync;
  logic strap_rail;
  logic top_off_req;
  logic izero;
  logic cc_phase;
  logic below_entry;
  logic above_exit;

  bssm_sync #(.WIDTH(6)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({oscillator_rate_strap, pwm_top_off, inductor_zero,
               constant_current_phase, charge_below_burst_entry,
               charge_above_burst_exit}),
    .sync_out(pins_sync)
  );

  assign strap_rail = pins_sync[5];
  assign top_off_req = pins_sync[4];
  assign izero = pins_sync[3];
  assign cc_phase = pins_sync[2];
  assign below_entry = pins_sync[1];
  assign above_exit = pins_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator
  logic [DIV_W-1:0] osc_cnt;
  wire [DIV_W-1:0] osc_last = strap_rail ? FAST_LAST : SLOW_LAST;
  wire cycle_end = (osc_cnt >= osc_last);
  wire cycle_start = (osc_cnt == '0);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= cycle_end ? '0 : osc_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-point sampling sequence
  bssm_pkg::bssm_mp_state_t mp_state;
  bssm_pkg::bssm_mp_state_t next_mp_state;
  logic [MP_W-1:0] mp_cnt;
  logic [MP_W-1:0] next_mp_cnt;
  wire mp_run = (mp_state == bssm_pkg::BSSM_RUN);
  wire mp_capture = (mp_state == bssm_pkg::BSSM_SAMPLE);

  always_comb begin
    next_mp_state = mp_state;
    next_mp_cnt = mp_cnt + 1'b1;
    unique case (mp_state)
      bssm_pkg::BSSM_RUN: begin
        if (mp_cnt >= INTERVAL_LAST) begin
          next_mp_state = bssm_pkg::BSSM_SETTLE;
          next_mp_cnt = '0;
        end
      end
      bssm_pkg::BSSM_SETTLE: begin
        if (mp_cnt >= SETTLE_LAST) begin
          next_mp_state = bssm_pkg::BSSM_SAMPLE;
          next_mp_cnt = '0;
        end
      end
      bssm_pkg::BSSM_SAMPLE: begin
        next_mp_state = bssm_pkg::BSSM_RUN;
        next_mp_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mp_state <= bssm_pkg::BSSM_RUN;
      mp_cnt <= '0;
    end else begin
      mp_state <= next_mp_state;
      mp_cnt <= next_mp_cnt;
    end
  end

  // The divided input arrives as a code; the held copy is only replaced here
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      held_sample <= '0;
      sample_valid <= 1'b0;
    end else if (mp_capture) begin
      held_sample <= open_circuit_code;
      sample_valid <= 1'b1;
    end
  end

  // Until a first sample exists there is nothing to regulate against
  wire below_sample = sample_valid && (power_point_sense_code < held_sample);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      charger_enable <= 1'b0;
      charge_reduce <= 1'b0;
    end else begin
      charger_enable <= (next_mp_state == bssm_pkg::BSSM_RUN);
      charge_reduce <= mp_run && below_sample;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst operation with hysteresis
  logic [1:0] burst_cnt;
  wire burst_enter = !cc_phase && below_entry;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      burst_active <= 1'b0;
      burst_cnt <= '0;
    end else begin
      if (above_exit) begin
        burst_active <= 1'b0;
      end else if (burst_enter) begin
        burst_active <= 1'b1;
      end
      if (cycle_start) begin
        burst_cnt <= (burst_cnt >= BURST_LAST) ? '0 : burst_cnt + 1'b1;
      end
    end
  end

  // Only one cycle in BURST_DIV switches while in burst; the rest idle
  wire burst_standby = burst_active && (burst_cnt != '0);
  wire switch_allowed = mp_run && !burst_standby;

  ////////////////////////////////////////////////////////////////////////////
  // Dropout and bootstrap refresh counters
  logic [3:0] drop_cnt;
  logic [5:0] refr_cnt;
  logic [2:0] pulse_cnt;
  logic next_top;
  logic next_bottom;
  logic [2:0] next_pulse;
  wire drop_hit = (drop_cnt >= DROP_LIMIT);
  wire refr_due = (refr_cnt >= REFR_LIMIT);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drop_cnt <= '0;
      refr_cnt <= '0;
    end else begin
      if (top_switch_on && !next_top) begin
        drop_cnt <= '0;
      end else if (cycle_start) begin
        drop_cnt <= (top_switch_on && !drop_hit) ? drop_cnt + 1'b1 :
                    (top_switch_on ? drop_cnt : '0);
      end
      if (next_bottom && !bottom_switch_on) begin
        refr_cnt <= '0;
      end else if (cycle_start && !refr_due) begin
        refr_cnt <= refr_cnt + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequencing; the two switches are never driven on together
  always_comb begin
    next_top = top_switch_on;
    next_bottom = bottom_switch_on;
    next_pulse = '0;
    if (!switch_allowed) begin
      next_top = 1'b0;
      next_bottom = 1'b0;
    end else if (cycle_start) begin
      if (refr_due) begin
        next_top = 1'b0;
        next_bottom = 1'b1;
        next_pulse = REFR_PULSE;
      end else if (!top_switch_on) begin
        next_top = 1'b1;
        next_bottom = 1'b0;
      end
    end else if (pulse_cnt != '0) begin
      next_pulse = pulse_cnt - 1'b1;
      if (pulse_cnt == 3'h1) begin
        next_bottom = 1'b0;
        next_top = 1'b1;
      end
    end else if (top_switch_on && (top_off_req || drop_hit)) begin
      next_top = 1'b0;
      next_bottom = !izero;
    end else if (bottom_switch_on && izero) begin
      next_bottom = 1'b0;
    end
    // Dropout force ends with the cycle, which the restart above handles
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      top_switch_on <= 1'b0;
      bottom_switch_on <= 1'b0;
      pulse_cnt <= '0;
    end else begin
      top_switch_on <= next_top;
      bottom_switch_on <= next_bottom;
      pulse_cnt <= next_pulse;
    end
  end
endmodule // bssm_core
`default_nettype wire

// ---- common/bssm_pkg.sv ----
package bssm_pkg;
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned OSC_FAST_HZ = 1_500_000;
  localparam int unsigned OSC_SLOW_HZ = 750_000;
  // Both periods round down
  localparam int unsigned OSC_FAST_DIV = SYS_CLK_HZ / OSC_FAST_HZ;
  localparam int unsigned OSC_SLOW_DIV = SYS_CLK_HZ / OSC_SLOW_HZ;
  localparam int unsigned DROPOUT_LIMIT = 8;
  localparam int unsigned REFRESH_LIMIT = 32;
  localparam int unsigned REFRESH_PULSE = 4;
  localparam int unsigned BURST_DIV = 4;
  localparam int unsigned SETTLE_MS = 36;
  localparam int unsigned SETTLE_CYCLES = SETTLE_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned SAMPLE_INTERVAL_MS = 1000;
  localparam int unsigned SAMPLE_INTERVAL_CYCLES =
    SAMPLE_INTERVAL_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned SAMPLE_WIDTH = 10;

  typedef enum logic [2:0] {
    BSSM_RUN    = 3'h1,
    BSSM_SETTLE = 3'h2,
    BSSM_SAMPLE = 3'h4
  } bssm_mp_state_t;
endpackage

// ---- verilog/bssm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module bssm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds the second only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // bssm_sync
`default_nettype wire

// ---- tb/bssm_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module bssm_props #(
  parameter int unsigned SETTLE_CYCLES = 50,
  parameter int unsigned INTERVAL_CYCLES = 280,
  parameter int unsigned SAMPLE_WIDTH = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic oscillator_rate_strap,
  input wire logic pwm_top_off,
  input wire logic inductor_zero,
  input wire logic constant_current_phase,
  input wire logic charge_below_burst_entry,
  input wire logic charge_above_burst_exit,
  input wire logic [SAMPLE_WIDTH-1:0] open_circuit_code,
  input wire logic [SAMPLE_WIDTH-1:0] power_point_sense_code,
  input wire logic top_switch_on,
  input wire logic bottom_switch_on,
  input wire logic charger_enable,
  input wire logic burst_active,
  input wire logic charge_reduce,
  input wire logic [SAMPLE_WIDTH-1:0] held_sample,
  input wire logic sample_valid
);
  // Enable stays low for the settle count plus the one sampling clock
  localparam int SL = SETTLE_CYCLES;
  localparam int IL = INTERVAL_CYCLES - 4;
  localparam int TMAX = 8 * bssm_pkg::OSC_SLOW_DIV + 4;
  int ton;
  logic below;
  assign below = power_point_sense_code < held_sample;
  // Unbroken top on-time; bounded by the slow rate so strap is free
  always_ff @(posedge sys_clk) begin
    ton <= (rst || !top_switch_on) ? 0 : ton + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_settle;
    ((!charger_enable) throughout (##SL 1'b1)) ##1 charger_enable;
  endsequence
  AST_SETTLE: assert property ($fell(charger_enable) |-> s_settle)
    else $error("settle length wrong");
  AST_RUN: assert property ($rose(charger_enable) |->
    (charger_enable throughout (##IL 1'b1)) ##[1:8] $fell(charger_enable))
    else $error("sample interval wrong");
  AST_OFF: assert property (!charger_enable [*2] |->
    !top_switch_on && !bottom_switch_on)
    else $error("switching in standby");
  AST_TAKE: assert property ($rose(charger_enable) && !$past(rst, 2) |->
    held_sample == $past(open_circuit_code) && sample_valid)
    else $error("sample not captured");
  AST_HOLD: assert property ($changed(held_sample) |->
    $rose(charger_enable))
    else $error("held sample drifted");
  AST_REDUCE: assert property ($rose(charge_reduce) |->
    $past(below) && $past(sample_valid))
    else $error("reduce without cause");
  AST_REDUCE_ON: assert property ((below && sample_valid && charger_enable) [*3] |-> charge_reduce)
    else $error("reduce missing");
  AST_DROPOUT: assert property (ton <= TMAX)
    else $error("top on too long");
  AST_BURST_IN: assert property ((!constant_current_phase &&
    charge_below_burst_entry && !charge_above_burst_exit) [*4] |-> burst_active)
    else $error("burst not entered");
  AST_BURST_KEEP: assert property ((!charge_above_burst_exit) [*3] ##0
    burst_active |=> burst_active)
    else $error("burst left early");
endmodule // bssm_props
bind bssm_core bssm_props #(
  .SETTLE_CYCLES(SETTLE_CYCLES),
  .INTERVAL_CYCLES(INTERVAL_CYCLES),
  .SAMPLE_WIDTH(SAMPLE_WIDTH)
) u_props (.*);
`default_nettype wire

// ---- tb/bssm_plant.sv ----
`timescale 1ns/1ps
`default_nettype none
module bssm_plant (
  input wire logic sys_clk,
  input wire logic top_switch_on,
  input wire logic charger_enable,
  input wire logic [7:0] on_time,
  input wire logic [9:0] voc,
  input wire logic [9:0] vload,
  output logic pwm_top_off,
  output logic inductor_zero,
  output logic [9:0] open_circuit_code,
  output logic [9:0] power_point_sense_code
);
  logic top_q = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic [1:0] loaded = 2'h0;
  always_ff @(posedge sys_clk) begin
    top_q <= top_switch_on;
    cnt <= (top_switch_on !== top_q) ? 8'h00 : cnt + {7'h00, cnt != 8'hFF};
    loaded <= {loaded[0], charger_enable};
  end
  // On-time FF never asks the top switch off, forcing dropout
  assign pwm_top_off = top_switch_on && on_time != 8'hFF && cnt >= on_time;
  assign inductor_zero = !top_switch_on && cnt >= 8'h08;
  // Input sags only after some loaded clocks, so a sample sees voc
  assign open_circuit_code = &loaded ? vload : voc;
  assign power_point_sense_code = open_circuit_code;
endmodule // bssm_plant
`default_nettype wire

// ---- tb/bssm_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bssm_core_tb;
  localparam int unsigned SETTLE_CYCLES = 50;
  localparam int unsigned INTERVAL_CYCLES = 280;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic oscillator_rate_strap = 1'b1;
  logic constant_current_phase = 1'b1;
  logic charge_below_burst_entry = 1'b0;
  logic charge_above_burst_exit = 1'b0;
  logic [7:0] on_time = 8'h05;
  logic [9:0] voc = 10'h190;
  logic [9:0] vload = 10'h12C;
  logic pwm_top_off, inductor_zero, top_switch_on, bottom_switch_on;
  logic charger_enable, burst_active, charge_reduce, sample_valid;
  logic [9:0] open_circuit_code, power_point_sense_code, held_sample;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  bssm_core #(
    .SETTLE_CYCLES(SETTLE_CYCLES),
    .INTERVAL_CYCLES(INTERVAL_CYCLES)
  ) DUT (.*);
  bssm_plant u_plant (.*);
  task automatic end_of_test;
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // 0 enable, 1 top, 2 bottom; n is edges until the level shows
  task automatic wait_for(input int s, input logic v, output int n);
    n = 0;
    while (((s == 0) ? charger_enable : (s == 1) ? top_switch_on :
        bottom_switch_on) !== v && n < 1000) begin
      step(1);
      n++;
    end
  endtask
  task automatic t_oscillator_rate_strap(input logic s, input int p);
    int n;
    int m;
    oscillator_rate_strap = s;
    wait_for(0, 1'b0, n);
    wait_for(0, 1'b1, n);
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, n);
    wait_for(1, 1'b1, m);
    check("period", n + m, p);
  endtask
  task automatic t_dropout;
    int n;
    on_time = 8'hFF;
    wait_for(0, 1'b0, n);
    wait_for(0, 1'b1, n);
    wait_for(2, 1'b1, n);
    check("dropout delay", n >= 182 && n <= 236, 1'b1);
    check("dropout top", top_switch_on, 1'b0);
    step(14);
    check("dropout end", bottom_switch_on, 1'b0);
    on_time = 8'h05;
  endtask
  task automatic t_power_point_sense;
    int n;
    wait_for(0, 1'b0, n);
    wait_for(0, 1'b1, n);
    check("settle", n, SETTLE_CYCLES + 1);
    step(1);
    check("held", held_sample, voc);
    check("valid", sample_valid, 1'b1);
    check("resume", charger_enable, 1'b1);
    step(6);
    check("reduce", charge_reduce, 1'b1);
    vload = 10'h1F4;
    step(4);
    check("no reduce", charge_reduce, 1'b0);
    voc = 10'h1C2;
    step(20);
    check("held kept", held_sample, 10'h190);
    wait_for(0, 1'b0, n);
    wait_for(0, 1'b1, n);
    step(1);
    check("held new", held_sample, voc);
  endtask
  task automatic t_burst;
    constant_current_phase = 1'b0;
    charge_below_burst_entry = 1'b1;
    step(4);
    check("burst on", burst_active, 1'b1);
    charge_below_burst_entry = 1'b0;
    step(4);
    check("burst held", burst_active, 1'b1);
    charge_above_burst_exit = 1'b1;
    step(4);
    check("burst off", burst_active, 1'b0);
    charge_above_burst_exit = 1'b0;
    constant_current_phase = 1'b1;
    charge_below_burst_entry = 1'b1;
    step(4);
    check("burst in cc", burst_active, 1'b0);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    step(2);
    rst = 1'b0;
    t_oscillator_rate_strap(1'b1, bssm_pkg::OSC_FAST_DIV);
    t_oscillator_rate_strap(1'b0, bssm_pkg::OSC_SLOW_DIV);
    oscillator_rate_strap = 1'b1;
    t_dropout();
    t_power_point_sense();
    t_burst();
    end_of_test();
  end
endmodule // bssm_core_tb
`default_nettype wire
